// [fcr_pkg.sv]
// Constants and types of the float convert and reciprocal square root unit
package fcr_pkg;
	// Opcode words
	localparam logic [15:0] OPLO_RSQRT     = 16'he692;
	localparam logic [15:0] OPLO_S16       = 16'he68c;
	localparam logic [15:0] OPLO_S32       = 16'he688;
	localparam logic [15:0] OPLO_U16       = 16'he68e;
	localparam logic [15:0] HI_RSVD_MASK   = 16'h7fc0;
	localparam int          HI_ROUND_BIT   = 15;
	localparam int          FLD_W          = 3;
	localparam int          NREG           = 8;
	// Register map, byte addresses
	localparam int          AW             = 12;
	localparam logic [11:0] ADDR_STATUS    = 12'h000;
	localparam logic [11:0] ADDR_MASK      = 12'h004;
	localparam logic [11:0] ADDR_REGS      = 12'h020;
	// Status and mask layout
	localparam int          ST_UFLOW       = 0;
	localparam int          ST_OFLOW       = 1;
	localparam int          ST_ILL         = 2;
	localparam int          ST_W           = 3;
	localparam logic [2:0]  ST_RESET       = 3'h0;
	// Float constants
	localparam logic [7:0]  EXP_MAX        = 8'hff;
	localparam logic [7:0]  EXP_ZERO       = 8'h00;
	localparam logic [31:0] RSQRT_MAGIC    = 32'h5f3759df;
	localparam logic [31:0] FLT_MAX_POS    = 32'h7f7fffff;
	localparam logic [31:0] FLT_POS_ZERO   = 32'h00000000;
	localparam logic [31:0] THREE_HALF_Q30 = 32'h60000000;
	localparam logic [9:0]  NEWTON_SH_BASE = 10'h18d;
	// Conversion thresholds: below 2^-9 is zero, from 2^31 on saturates
	localparam logic [7:0]  CONV_EXP_ZERO  = 8'h76;
	localparam logic [7:0]  CONV_EXP_SAT   = 8'h9e;
	localparam logic [32:0] MAG_HUGE       = 33'h100000000;
	localparam logic [33:0] S16_MAX        = 34'h000007fff;
	localparam logic [33:0] S16_MIN        = 34'h3ffff8000;
	localparam logic [33:0] S32_MAX        = 34'h07fffffff;
	localparam logic [33:0] S32_MIN        = 34'h380000000;
	localparam logic [33:0] U16_MAX        = 34'h00000ffff;
	localparam logic [33:0] U16_MIN        = 34'h000000000;

	typedef enum logic [2:0] {
		OP_NONE  = 3'b000,
		OP_RSQRT = 3'b001,
		OP_S16T  = 3'b010,
		OP_S16R  = 3'b011,
		OP_S32T  = 3'b100,
		OP_U16T  = 3'b101
	} fcr_op_t;

	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
	} fcr_inst_t;

	typedef struct packed {
		logic             valid;
		fcr_op_t          op;
		logic [FLD_W-1:0] dest;
		logic [31:0]      src;
	} fcr_stage_t;
endpackage : fcr_pkg

// [fcr_unit.sv]
// Float convert and reciprocal square root execution unit with APB registers
`timescale 1ns/10ps
module fcr_unit (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  inst_valid,
	input  wire fcr_pkg::fcr_inst_t    inst,
	output logic                       wb_valid,
	output logic      [2:0]            wb_dest,
	output logic                       irq
);
	import fcr_pkg::*;

	fcr_stage_t        stage_q;
	fcr_stage_t        stage_d;
	logic [31:0]       fpr_q [NREG];
	logic [ST_W-1:0]   status_q;
	logic [ST_W-1:0]   mask_q;
	logic [31:0]       prdata_q;
	logic              wb_valid_q;
	logic [FLD_W-1:0]  wb_dest_q;
	logic [31:0]       result;
	logic [33:0]       rs_out;
	logic              ev_uflow;
	logic              ev_oflow;
	logic              ev_ill;
	logic              hit_status;
	logic              hit_mask;
	logic              hit_regs;
	logic              hit;
	logic              apb_wr;
	logic [FLD_W-1:0]  reg_idx;

	// Float to integer with truncation or round-to-even, then clamp per mode
	function automatic logic [31:0] f2i(input logic [31:0] f, input fcr_op_t op);
		logic [7:0]         ex;
		logic [63:0]        fix;
		logic [32:0]        mag;
		logic               inc;
		logic signed [33:0] val;
		logic signed [33:0] hi;
		logic signed [33:0] lo;
		logic [31:0]        res;
		ex  = f[30:23];
		fix = '0;
		mag = '0;
		inc = 1'b0;
		hi  = $signed(S32_MAX);
		lo  = $signed(S32_MIN);
		if (op == OP_S16T || op == OP_S16R) begin
			hi = $signed(S16_MAX);
			lo = $signed(S16_MIN);
		end else if (op == OP_U16T) begin
			hi = $signed(U16_MAX);
			lo = $signed(U16_MIN);
		end
		if (ex >= CONV_EXP_SAT) begin
			mag = MAG_HUGE;
		end else if (ex >= CONV_EXP_ZERO) begin
			// Fixed point with 32 fraction bits; truncation just drops them
			fix = {40'h0, 1'b1, f[22:0]} << (ex - CONV_EXP_ZERO);
			inc = (op == OP_S16R) && fix[31] && ((fix[30:0] != '0) || fix[32]);
			mag = {1'b0, fix[63:32]} + {32'h0, inc};
		end
		val = f[31] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
		if (ex == EXP_MAX && f[22:0] != '0) begin
			val = hi;
		end else if (val > hi) begin
			val = hi;
		end else if (val < lo) begin
			val = lo;
		end
		unique case (op)
			OP_S16T, OP_S16R: res = {{16{val[15]}}, val[15:0]};
			OP_U16T:          res = {16'h0000, val[15:0]};
			default:          res = val[31:0];
		endcase
		return res;
	endfunction : f2i

	// Rsqrt estimate: magic seed plus one Newton step; returns {underflow, overflow, value}
	function automatic logic [33:0] rsqrt_est(input logic [31:0] f);
		logic [31:0] ax;
		logic [31:0] y0;
		logic [23:0] mx;
		logic [23:0] my;
		logic [47:0] p1;
		logic [48:0] p2;
		logic [9:0]  sh;
		logic [31:0] tq;
		logic [31:0] fq;
		logic [55:0] p3;
		logic [7:0]  ey;
		logic [22:0] mr;
		logic [33:0] r;
		ax = {1'b0, f[30:0]};
		y0 = RSQRT_MAGIC - (ax >> 1);
		mx = {1'b1, ax[22:0]};
		my = {1'b1, y0[22:0]};
		ey = y0[30:23];
		p1 = mx * my;
		p2 = p1[47:23] * my;
		sh = NEWTON_SH_BASE - ({2'b00, ax[30:23]} + {1'b0, y0[30:23], 1'b0});
		tq = 32'(p2 >> sh);
		fq = THREE_HALF_Q30 - {1'b0, tq[31:1]};
		p3 = my * fq;
		// Newton factor stays near one, so at most one place of renormalising
		if (p3[54]) begin
			mr = p3[53:31];
			ey = ey + 8'h01;
		end else if (p3[53]) begin
			mr = p3[52:30];
		end else begin
			mr = p3[51:29];
			ey = ey - 8'h01;
		end
		r = {2'b00, 1'b0, ey, mr};
		// Negative input uses its magnitude so no not-a-number can appear
		if (ax[30:23] == EXP_MAX) begin
			r = {1'b1, 1'b0, FLT_POS_ZERO};
		end else if (ax[30:23] == EXP_ZERO) begin
			r = {1'b0, 1'b1, FLT_MAX_POS};
		end
		return r;
	endfunction : rsqrt_est

	// Decode of the issued instruction
	always_comb begin
		stage_d       = '0;
		stage_d.dest  = inst.hi[FLD_W-1:0];
		stage_d.src   = fpr_q[inst.hi[2*FLD_W-1:FLD_W]];
		stage_d.op    = OP_NONE;
		ev_ill        = 1'b0;
		if (inst_valid) begin
			if ((inst.hi & HI_RSVD_MASK) != '0) begin
				ev_ill = 1'b1;
			end else if (inst.lo == OPLO_S16) begin
				stage_d.op = inst.hi[HI_ROUND_BIT] ? OP_S16R : OP_S16T;
			end else if (inst.hi[HI_ROUND_BIT]) begin
				ev_ill = 1'b1;
			end else if (inst.lo == OPLO_RSQRT) begin
				stage_d.op = OP_RSQRT;
			end else if (inst.lo == OPLO_S32) begin
				stage_d.op = OP_S32T;
			end else if (inst.lo == OPLO_U16) begin
				stage_d.op = OP_U16T;
			end else begin
				ev_ill = 1'b1;
			end
		end
		stage_d.valid = (stage_d.op != OP_NONE);
	end

	// Execute stage register; the operand is sampled at issue
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_q <= '0;
		end else begin
			stage_q <= stage_d;
		end
	end

	// Second pipeline cycle result
	always_comb begin
		rs_out = rsqrt_est(stage_q.src);
		ev_uflow = stage_q.valid && (stage_q.op == OP_RSQRT) && rs_out[33];
		ev_oflow = stage_q.valid && (stage_q.op == OP_RSQRT) && rs_out[32];
		if (stage_q.op == OP_RSQRT) begin
			result = rs_out[31:0];
		end else begin
			result = f2i(stage_q.src, stage_q.op);
		end
	end

	// APB decode; zero wait states, read data loaded in the setup cycle
	assign hit_status = (paddr == ADDR_STATUS);
	assign hit_mask   = (paddr == ADDR_MASK);
	assign hit_regs   = (paddr[11:5] == ADDR_REGS[11:5]) && (paddr[1:0] == 2'b00);
	assign hit        = hit_status || hit_mask || hit_regs;
	assign reg_idx    = paddr[4:2];
	assign apb_wr     = psel && penable && pwrite && hit;
	assign pready     = 1'b1;
	assign pslverr    = psel && penable && !hit;

	// Register file; writeback beats a same-cycle software write
	generate
		for (genvar i = 0; i < NREG; i++) begin : g_fpr
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					fpr_q[i] <= '0;
				end else if (stage_q.valid && stage_q.dest == FLD_W'(i)) begin
					fpr_q[i] <= result;
				end else if (apb_wr && hit_regs && reg_idx == FLD_W'(i)) begin
					fpr_q[i] <= pwdata;
				end
			end
		end
	endgenerate

	// Sticky status: a new event wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= ST_RESET;
		end else begin
			status_q <= (status_q & ~((apb_wr && hit_status) ? pwdata[ST_W-1:0] : '0))
				| {ev_ill, ev_oflow, ev_uflow};
		end
	end

	// Interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= ST_RESET;
		end else if (apb_wr && hit_mask) begin
			mask_q <= pwdata[ST_W-1:0];
		end
	end

	// Read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (psel && !penable && !pwrite) begin
			if (hit_status) begin
				prdata_q <= {29'h0, status_q};
			end else if (hit_mask) begin
				prdata_q <= {29'h0, mask_q};
			end else if (hit_regs) begin
				prdata_q <= fpr_q[reg_idx];
			end else begin
				prdata_q <= '0;
			end
		end
	end

	// Writeback indication for the issuing core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wb_valid_q <= 1'b0;
			wb_dest_q  <= '0;
		end else begin
			wb_valid_q <= stage_q.valid;
			wb_dest_q  <= stage_q.dest;
		end
	end

	assign prdata   = prdata_q;
	assign wb_valid = wb_valid_q;
	assign wb_dest  = wb_dest_q;
	assign irq      = |(status_q & mask_q);

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_decode_rsqrt;
		inst_valid && inst.lo == OPLO_RSQRT && inst.hi[15:6] == '0
			|=> stage_q.valid && stage_q.op == OP_RSQRT;
	endproperty
	a_decode_rsqrt: assert property (p_decode_rsqrt) else $error("rsqrt not decoded");

	property p_round_decode;
		inst_valid && inst.lo == OPLO_S16 && inst.hi[15:6] == 10'h200
			|=> stage_q.op == OP_S16R;
	endproperty
	a_round_decode: assert property (p_round_decode) else $error("round select lost");

	property p_two_cycle;
		stage_d.valid ##1 1'b1 |=> fpr_q[$past(stage_q.dest)] == $past(result) && wb_valid;
	endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("result not written in time");

	property p_rsqrt_clean;
		stage_q.valid && stage_q.op == OP_RSQRT
			|-> !result[31] && result[30:23] != EXP_MAX
			&& (result[30:23] != EXP_ZERO || result[22:0] == '0);
	endproperty
	a_rsqrt_clean: assert property (p_rsqrt_clean) else $error("rsqrt bad encoding");

	property p_uflow_set;
		ev_uflow |=> status_q[ST_UFLOW];
	endproperty
	a_uflow_set: assert property (p_uflow_set) else $error("underflow flag not set");

	property p_oflow_set;
		stage_q.valid && stage_q.op == OP_RSQRT && stage_q.src[30:23] == EXP_ZERO
			|=> status_q[ST_OFLOW];
	endproperty
	a_oflow_set: assert property (p_oflow_set) else $error("overflow flag not set");

	property p_s16_ext;
		stage_q.valid && (stage_q.op == OP_S16T || stage_q.op == OP_S16R)
			|-> result[31:16] == {16{result[15]}};
	endproperty
	a_s16_ext: assert property (p_s16_ext) else $error("s16 not sign extended");

	property p_u16_sat;
		stage_q.valid && stage_q.op == OP_U16T && !stage_q.src[31]
			&& stage_q.src[30:23] >= 8'h8f && stage_q.src[30:23] != EXP_MAX
			|-> result == 32'h0000ffff;
	endproperty
	a_u16_sat: assert property (p_u16_sat) else $error("u16 not saturated");

	property p_u16_hi;
		stage_q.valid && stage_q.op == OP_U16T |-> result[31:16] == 16'h0000;
	endproperty
	a_u16_hi: assert property (p_u16_hi) else $error("u16 upper half not zero");

	property p_conv_flags;
		stage_q.valid && stage_q.op != OP_RSQRT && !(apb_wr && hit_status)
			|=> status_q[ST_OFLOW:ST_UFLOW] == $past(status_q[ST_OFLOW:ST_UFLOW]);
	endproperty
	a_conv_flags: assert property (p_conv_flags) else $error("conversion touched flags");

	property p_nan_max;
		stage_q.valid && stage_q.op == OP_S32T && stage_q.src[30:23] == EXP_MAX
			&& stage_q.src[22:0] != '0 |-> result == 32'h7fffffff;
	endproperty
	a_nan_max: assert property (p_nan_max) else $error("nan not most positive");

	c_rsqrt: cover property (stage_q.valid && stage_q.op == OP_RSQRT ##1 wb_valid);
	c_round: cover property (stage_q.valid && stage_q.op == OP_S16R && result[15]);
	c_irq:   cover property (!irq ##1 irq);
	c_err:   cover property (pslverr);
endmodule : fcr_unit

// [fcr_host_model.sv]
// Issue side of the host core: one instruction, then an empty slot
`timescale 1ns/10ps
module fcr_host_model (
	input  wire logic           pclk,
	output logic                inst_valid,
	output fcr_pkg::fcr_inst_t  inst
);
	import fcr_pkg::*;

	// Edge counter, read by the bench to time writebacks
	int n = 0;

	always @(posedge pclk) begin
		n <= n + 1;
	end

	initial begin
		inst_valid = 1'b0;
		inst = 32'h0;
	end

	// One issue; at returns the count seen at the launching edge
	task automatic issue(input logic [15:0] lo, input logic rnd, input logic [2:0] s,
		input logic [2:0] d, output int at);
		@(posedge pclk);
		at = n;
		inst_valid <= 1'b1;
		inst <= {rnd, 9'h0, s, d, lo};
		@(posedge pclk);
		// Slot stays empty; word inverted so no stale opcode lingers
		inst_valid <= 1'b0;
		inst <= ~inst;
	endtask : issue
endmodule : fcr_host_model

// [testbench.sv]
// Self-checking bench of the float convert and reciprocal square root unit
`timescale 1ns/10ps
module testbench;
	import fcr_pkg::*;

	typedef struct {bit rd; logic [31:0] d; int tol; bit err;} fcr_rq_t;
	typedef struct {logic [2:0] d; int t;} fcr_wq_t;

	logic        pclk, presetn, psel, penable, pwrite;
	logic        pready, pslverr, inst_valid, wb_valid, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [31:0] lf = 32'h0000005b;
	logic [2:0]  wb_dest;
	fcr_inst_t   inst;
	fcr_rq_t     rq[$];
	fcr_wq_t     wq[$];
	fcr_rq_t     r_cur;
	fcr_wq_t     w_cur;
	int          n_fail = 0;
	int          total_checks = 0;

	// Conversion and estimate cases: opcode, round bit, input, result
	logic [15:0] c_lo[16] = '{OPLO_S16, OPLO_S16, OPLO_S16, OPLO_S16, OPLO_S16, OPLO_S16,
		OPLO_S32, OPLO_S32, OPLO_S32, OPLO_U16, OPLO_U16, OPLO_U16,
		OPLO_RSQRT, OPLO_RSQRT, OPLO_RSQRT, OPLO_RSQRT};
	logic        c_rn[16] = '{0, 0, 0, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
	logic [31:0] c_in[16] = '{32'h40a00000, 32'hc0a00000, 32'h48927c00, 32'h3fd9999a,
		32'hbfd9999a, 32'h40200000, 32'h4b2af5a5, 32'hcb2af5a5, 32'h7fc00000,
		32'h48927c00, 32'hc0a00000, 32'h41100000, 32'h40800000, 32'h3e800000,
		32'h00000000, 32'h7f800000};
	logic [31:0] c_ex[16] = '{32'h00000005, 32'hfffffffb, 32'h00007fff, 32'h00000002,
		32'hfffffffe, 32'h00000002, 32'h00aaf5a5, 32'hff550a5b, 32'h7fffffff,
		32'h0000ffff, 32'h00000000, 32'h00000009, 32'h3f000000, 32'h40000000,
		32'h7f7fffff, 32'h00000000};

	fcr_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .inst_valid(inst_valid), .inst(inst), .wb_valid(wb_valid),
		.wb_dest(wb_dest), .irq(irq));

	fcr_host_model u_host (.pclk(pclk), .inst_valid(inst_valid), .inst(inst));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic cmp_word(input logic [31:0] g, input logic [31:0] e, input int tol);
		total_checks++;
		if ($isunknown(g) || (tol == 0 ? g !== e : (int'(g) - int'(e) > tol
			|| int'(e) - int'(g) > tol))) begin
			n_fail++;
			$display("[ERR] %0t word %h expected %h", $time, g, e);
		end
	endtask : cmp_word

	task automatic cmp_bit(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t bit %b expected %b", $time, g, e);
		end
	endtask : cmp_bit

	task automatic close_out();
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	// One APB transfer; the expectation is queued before it starts
	task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] e, input int tol, input bit err);
		rq.push_back('{rd: !w, d: e, tol: tol, err: err});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input bit err = 0);
		apb(1'b1, a, d, 32'h0, 0, err);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input int tol = 0,
		input bit err = 0);
		apb(1'b0, a, 32'h0, e, tol, err);
	endtask : rd

	// Issue; a legal one expects its writeback three counts later
	task automatic op(input logic [15:0] lo, input logic rnd, input logic [2:0] s,
		input logic [2:0] d, input bit ok = 1);
		int at;
		u_host.issue(lo, rnd, s, d, at);
		if (ok)
			wq.push_back('{d: d, t: at + 3});
	endtask : op

	task automatic irq_is(input logic e);
		@(negedge pclk);
		cmp_bit(irq, e);
	endtask : irq_is

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h000000c5 : 32'h0);
	endfunction : lfsr_next

	// APB completions are matched against the oldest note
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			r_cur = rq.pop_front();
			cmp_bit(pslverr, r_cur.err);
			if (r_cur.rd)
				cmp_word(prdata, r_cur.d, r_cur.tol);
		end
	end

	// Writeback pulses: destination and exact cycle
	always @(posedge pclk) begin
		if (wb_valid === 1'b1) begin
			w_cur = wq.pop_front();
			cmp_word({29'h0, wb_dest}, {29'h0, w_cur.d}, 0);
			cmp_word(u_host.n, w_cur.t, 0);
		end
	end

	initial begin
		#50000;
		n_fail++;
		close_out();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_STATUS, 32'h0);
		rd(ADDR_REGS, 32'h0);
		// Every mode, source and destination field across the table
		for (int i = 0; i < 16; i++) begin
			if (i == 14)
				rd(ADDR_STATUS, 32'h0);
			wr(ADDR_REGS + 12'(4 * (i % 8)), c_in[i]);
			op(c_lo[i], c_rn[i], 3'(i), 3'(i + 3));
			rd(ADDR_REGS + 12'(4 * ((i + 3) % 8)), c_ex[i], (i == 12 || i == 13) ? 32768 : 0);
		end
		rd(ADDR_STATUS, 32'h3);
		// Dependent instruction two slots later sees the new value
		wr(ADDR_REGS, 32'h40a00000);
		wr(ADDR_REGS + 12'h004, 32'h42c80000);
		op(OPLO_S16, 1'b0, 3'd0, 3'd1);
		op(OPLO_S32, 1'b0, 3'd1, 3'd0);
		rd(ADDR_REGS, 32'h0);
		rd(ADDR_REGS + 12'h004, 32'h5);
		// Sticky flags, mask and the level interrupt
		irq_is(1'b0);
		wr(ADDR_MASK, 32'h2);
		irq_is(1'b1);
		wr(ADDR_STATUS, 32'h1);
		irq_is(1'b1);
		rd(ADDR_STATUS, 32'h2);
		wr(ADDR_STATUS, 32'h2);
		irq_is(1'b0);
		rd(ADDR_STATUS, 32'h0);
		rd(ADDR_MASK, 32'h2);
		// Undecodable words never write back
		op(16'h1234, 1'b0, 3'd0, 3'd0, 0);
		rd(ADDR_STATUS, 32'h4);
		wr(ADDR_MASK, 32'h4);
		irq_is(1'b1);
		wr(ADDR_STATUS, 32'h4);
		irq_is(1'b0);
		op(OPLO_U16, 1'b1, 3'd1, 3'd2, 0);
		rd(ADDR_STATUS, 32'h4);
		// Unmapped and unaligned accesses are refused
		rd(12'h010, 32'h0, 0, 1);
		rd(12'h022, 32'h0, 0, 1);
		wr(12'h3fc, 32'hffffffff, 1);
		// Random register contents read back
		repeat (6) begin
			lf = lfsr_next(lf);
			wr(ADDR_REGS + 12'({lf[4:2], 2'b00}), lf);
			rd(ADDR_REGS + 12'({lf[4:2], 2'b00}), lf);
		end
		repeat (4) @(posedge pclk);
		cmp_word(32'(wq.size()), 32'h0, 0);
		close_out();
	end
endmodule : testbench
